// ### logic/setpoint_pkg.sv
package setpoint_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int TEMP_W = 16;
   localparam int CALC_W = 18;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;

   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_BASE      = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_OFFSET    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_AFTER_LD  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_BASE_MIN  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_BASE_MAX  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_OFF_MAX   = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_DEAD_ZONE = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_STBY_RED  = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_NIGHT_RED = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_STBY_INC  = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_NIGHT_INC = 8'h2C;
   localparam logic [ADDR_W-1:0] OFS_FROST_SP  = 8'h30;
   localparam logic [ADDR_W-1:0] OFS_HEAT_SP   = 8'h34;
   localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h38;
   localparam logic [ADDR_W-1:0] OFS_CUR_SP    = 8'h3C;

   // ************************************************************
   // Control and status fields
   // ************************************************************
   localparam int CTRL_MODE_LSB   = 0;
   localparam int CTRL_HC_AUTO    = 2;
   localparam int CTRL_COOL_OBJ   = 3;
   localparam int CTRL_ROT_OFFSET = 4;
   localparam logic [4:0] CTRL_RESET = 5'h14;

   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_COOL     = 2;
   localparam int STAT_WINDOW   = 3;
   localparam int STAT_ROT_LSB  = 16;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Cycles for the pin synchronisers to settle after reset
   // Four flops deep, so the cold-start level is valid one edge before the count ends
   localparam logic [2:0] SYNC_SETTLE = 3'h5;

   typedef enum logic [1:0]
   {
      MODE_COMFORT = 2'b00,
      MODE_STANDBY = 2'b01,
      MODE_NIGHT   = 2'b10,
      MODE_PROTECT = 2'b11
   } op_mode_type;

   // ************************************************************
   // Configuration parameters, 0.1 K per step, two's complement
   // ************************************************************
   typedef struct packed
   {
      logic signed [TEMP_W-1:0] after_load;
      logic signed [TEMP_W-1:0] base_min;
      logic signed [TEMP_W-1:0] base_max;
      logic signed [TEMP_W-1:0] off_max;
      logic signed [TEMP_W-1:0] dead_zone;
      logic signed [TEMP_W-1:0] stby_red;
      logic signed [TEMP_W-1:0] night_red;
      logic signed [TEMP_W-1:0] stby_inc;
      logic signed [TEMP_W-1:0] night_inc;
      logic signed [TEMP_W-1:0] frost_sp;
      logic signed [TEMP_W-1:0] heat_sp;
   } cfg_type;

   localparam cfg_type CFG_RESET = '{
      after_load : 16'h00D2,
      base_min   : 16'h0096,
      base_max   : 16'h012C,
      off_max    : 16'h0014,
      dead_zone  : 16'h0014,
      stby_red   : 16'h0014,
      night_red  : 16'h0028,
      stby_inc   : 16'h0014,
      night_inc  : 16'h0028,
      frost_sp   : 16'h0046,
      heat_sp    : 16'h0163
   };

   typedef struct packed
   {
      logic        rot_offset;
      logic        cool_obj;
      logic        hc_auto;
      op_mode_type mode_req;
   } ctrl_type;

endpackage

// ### logic/pin_sync.sv
`timescale 1ns/1ps

// Three-stage synchroniser; output moves once stages two and three agree
module pin_sync #(
   parameter int W = 1
)(
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   // Multi-bit values are only taken when both late stages match
   always_comb
   begin
      q_nxt = q_r;
      if (s2_r == s3_r)
      begin
         q_nxt = s3_r;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r  <= '0;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r  <= q_nxt;
      end
   end

   assign q = q_r;

endmodule // pin_sync

// ### logic/setpoint_calculator.sv
`timescale 1ns/1ps

module setpoint_calculator
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // AXI4-Lite slave
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // Pins
   input  wire logic        window_open_pin,
   input  wire logic        cooling_demand_pin,
   input  wire logic        cold_start_pin,
   input  wire logic [15:0] rotary_offset_pin,
   // To the control loop
   output logic [15:0]      cur_setpoint,
   output logic [1:0]       eff_mode,
   output logic             cooling_active
);

   localparam int TW = setpoint_pkg::TEMP_W;
   localparam int CW = setpoint_pkg::CALC_W;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic signed [CW-1:0] ext
   (
      input logic signed [TW-1:0] v
   );
      ext = CW'(v);
   endfunction

   function automatic logic signed [CW-1:0] clamp
   (
      input logic signed [CW-1:0] v,
      input logic signed [CW-1:0] lo,
      input logic signed [CW-1:0] hi
   );
      clamp = v;
      if (v < lo)
      begin
         clamp = lo;
      end
      else if (v > hi)
      begin
         clamp = hi;
      end
   endfunction

   function automatic logic [TW-1:0] merge
   (
      input logic [TW-1:0] old,
      input logic [31:0]   d,
      input logic [3:0]    s
   );
      merge = old;
      if (s[0])
      begin
         merge[7:0] = d[7:0];
      end
      if (s[1])
      begin
         merge[15:8] = d[15:8];
      end
   endfunction

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic        window_s;
   logic        cool_dem_s;
   logic        cold_s;
   logic [15:0] rot_s;

   pin_sync #(.W(3)) sync_bits
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       ({window_open_pin, cooling_demand_pin, cold_start_pin}),
      .q       ({window_s, cool_dem_s, cold_s})
   );

   pin_sync #(.W(16)) sync_rot
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .d       (rotary_offset_pin),
      .q       (rot_s)
   );

   // ************************************************************
   // Bus slave and object state
   // ************************************************************
   setpoint_pkg::cfg_type  cfg_r,      cfg_nxt;
   setpoint_pkg::ctrl_type ctrl_r,     ctrl_nxt;
   logic signed [TW-1:0]   base_r,     base_nxt;
   logic signed [TW-1:0]   offset_r,   offset_nxt;
   logic [15:0]            rot_prev_r, rot_prev_nxt;
   logic [2:0]             settle_r,   settle_nxt;
   logic                   aw_held_r,  aw_held_nxt;
   logic                   w_held_r,   w_held_nxt;
   logic [7:0]             waddr_r,    waddr_nxt;
   logic [31:0]            wdat_r,     wdat_nxt;
   logic [3:0]             wstb_r,     wstb_nxt;
   logic                   awready_r,  awready_nxt;
   logic                   wready_r,   wready_nxt;
   logic                   bvalid_r,   bvalid_nxt;
   logic [1:0]             bresp_r,    bresp_nxt;
   logic                   arready_r,  arready_nxt;
   logic                   rvalid_r,   rvalid_nxt;
   logic [1:0]             rresp_r,    rresp_nxt;
   logic [31:0]            rdata_r,    rdata_nxt;
   logic signed [TW-1:0]   cur_r,      cur_nxt;
   logic [1:0]             mode_r,     mode_nxt;
   logic                   cool_r,     cool_nxt;
   logic signed [CW-1:0]   wclamp;

   // Base object write, clamped to its limits as received
   assign wclamp = clamp(ext(wdat_r[TW-1:0]), ext(cfg_r.base_min),
                         ext(cfg_r.base_max));

   always_comb
   begin
      cfg_nxt      = cfg_r;
      ctrl_nxt     = ctrl_r;
      base_nxt     = base_r;
      offset_nxt   = offset_r;
      rot_prev_nxt = rot_s;
      settle_nxt   = settle_r;
      aw_held_nxt  = aw_held_r;
      w_held_nxt   = w_held_r;
      waddr_nxt    = waddr_r;
      wdat_nxt     = wdat_r;
      wstb_nxt     = wstb_r;
      bvalid_nxt   = bvalid_r;
      bresp_nxt    = bresp_r;
      rvalid_nxt   = rvalid_r;
      rresp_nxt    = rresp_r;
      rdata_nxt    = rdata_r;

      // Restore the retained base unless this is a first power-up
      if (settle_r != setpoint_pkg::SYNC_SETTLE)
      begin
         settle_nxt = settle_r + 3'h1;
         if (settle_r == setpoint_pkg::SYNC_SETTLE - 3'h1 && cold_s)
         begin
            base_nxt = cfg_r.after_load;
         end
      end

      // Rotary change replaces the offset when it acts as offset
      if (rot_s != rot_prev_r && ctrl_r.rot_offset)
      begin
         offset_nxt = rot_s;
      end

      if (awvalid && awready_r)
      begin
         aw_held_nxt = 1'b1;
         waddr_nxt   = awaddr;
      end
      if (wvalid && wready_r)
      begin
         w_held_nxt = 1'b1;
         wdat_nxt   = wdata;
         wstb_nxt   = wstrb;
      end

      if (aw_held_r && w_held_r && !bvalid_r)
      begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = setpoint_pkg::RESP_OKAY;
         case (waddr_r)
            setpoint_pkg::OFS_CTRL:
            begin
               if (wstb_r[0])
               begin
                  ctrl_nxt = setpoint_pkg::ctrl_type'(wdat_r[4:0]);
               end
            end
            setpoint_pkg::OFS_BASE:
            begin
               if (ctrl_r.rot_offset && wstb_r[1:0] == 2'h3)
               begin
                  base_nxt = wclamp[TW-1:0];
               end
            end
            setpoint_pkg::OFS_OFFSET:
               offset_nxt = merge(offset_r, wdat_r, wstb_r);
            setpoint_pkg::OFS_AFTER_LD:
            begin
               cfg_nxt.after_load = merge(cfg_r.after_load, wdat_r, wstb_r);
               base_nxt = cfg_nxt.after_load;
            end
            setpoint_pkg::OFS_BASE_MIN:
               cfg_nxt.base_min = merge(cfg_r.base_min, wdat_r, wstb_r);
            setpoint_pkg::OFS_BASE_MAX:
               cfg_nxt.base_max = merge(cfg_r.base_max, wdat_r, wstb_r);
            setpoint_pkg::OFS_OFF_MAX:
               cfg_nxt.off_max = merge(cfg_r.off_max, wdat_r, wstb_r);
            setpoint_pkg::OFS_DEAD_ZONE:
               cfg_nxt.dead_zone = merge(cfg_r.dead_zone, wdat_r, wstb_r);
            setpoint_pkg::OFS_STBY_RED:
               cfg_nxt.stby_red = merge(cfg_r.stby_red, wdat_r, wstb_r);
            setpoint_pkg::OFS_NIGHT_RED:
               cfg_nxt.night_red = merge(cfg_r.night_red, wdat_r, wstb_r);
            setpoint_pkg::OFS_STBY_INC:
               cfg_nxt.stby_inc = merge(cfg_r.stby_inc, wdat_r, wstb_r);
            setpoint_pkg::OFS_NIGHT_INC:
               cfg_nxt.night_inc = merge(cfg_r.night_inc, wdat_r, wstb_r);
            setpoint_pkg::OFS_FROST_SP:
               cfg_nxt.frost_sp = merge(cfg_r.frost_sp, wdat_r, wstb_r);
            setpoint_pkg::OFS_HEAT_SP:
               cfg_nxt.heat_sp = merge(cfg_r.heat_sp, wdat_r, wstb_r);
            setpoint_pkg::OFS_STATUS,
            setpoint_pkg::OFS_CUR_SP:
               bresp_nxt = setpoint_pkg::RESP_OKAY;
            default:
               bresp_nxt = setpoint_pkg::RESP_SLVERR;
         endcase
      end
      else if (bvalid_r && bready)
      begin
         bvalid_nxt = 1'b0;
      end

      if (arvalid && arready_r)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = setpoint_pkg::RESP_OKAY;
         rdata_nxt  = '0;
         case (araddr)
            setpoint_pkg::OFS_CTRL:      rdata_nxt[4:0] = ctrl_r;
            setpoint_pkg::OFS_BASE:      rdata_nxt[15:0] = base_r;
            setpoint_pkg::OFS_OFFSET:    rdata_nxt[15:0] = offset_r;
            setpoint_pkg::OFS_AFTER_LD:  rdata_nxt[15:0] = cfg_r.after_load;
            setpoint_pkg::OFS_BASE_MIN:  rdata_nxt[15:0] = cfg_r.base_min;
            setpoint_pkg::OFS_BASE_MAX:  rdata_nxt[15:0] = cfg_r.base_max;
            setpoint_pkg::OFS_OFF_MAX:   rdata_nxt[15:0] = cfg_r.off_max;
            setpoint_pkg::OFS_DEAD_ZONE: rdata_nxt[15:0] = cfg_r.dead_zone;
            setpoint_pkg::OFS_STBY_RED:  rdata_nxt[15:0] = cfg_r.stby_red;
            setpoint_pkg::OFS_NIGHT_RED: rdata_nxt[15:0] = cfg_r.night_red;
            setpoint_pkg::OFS_STBY_INC:  rdata_nxt[15:0] = cfg_r.stby_inc;
            setpoint_pkg::OFS_NIGHT_INC: rdata_nxt[15:0] = cfg_r.night_inc;
            setpoint_pkg::OFS_FROST_SP:  rdata_nxt[15:0] = cfg_r.frost_sp;
            setpoint_pkg::OFS_HEAT_SP:   rdata_nxt[15:0] = cfg_r.heat_sp;
            setpoint_pkg::OFS_STATUS:
            begin
               rdata_nxt[setpoint_pkg::STAT_MODE_LSB +: 2] = mode_r;
               rdata_nxt[setpoint_pkg::STAT_COOL]          = cool_r;
               rdata_nxt[setpoint_pkg::STAT_WINDOW]        = window_s;
               rdata_nxt[setpoint_pkg::STAT_ROT_LSB +: 16] = rot_s;
            end
            setpoint_pkg::OFS_CUR_SP:    rdata_nxt[15:0] = cur_r;
            default:
               rresp_nxt = setpoint_pkg::RESP_SLVERR;
         endcase
      end
      else if (rvalid_r && rready)
      begin
         rvalid_nxt = 1'b0;
      end

      // One write and one read in flight; readies drop while busy
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt  = !w_held_nxt && !bvalid_nxt;
      arready_nxt = !rvalid_nxt;
   end

   // ************************************************************
   // Set point datapath
   // ************************************************************
   logic signed [CW-1:0] base_c;
   logic signed [CW-1:0] off_c;
   logic signed [CW-1:0] sum_c;
   logic signed [CW-1:0] lim_c;

   always_comb
   begin
      // Window contact overrides any requested mode
      if (window_s)
      begin
         mode_nxt = setpoint_pkg::MODE_PROTECT;
      end
      else
      begin
         mode_nxt = ctrl_r.mode_req;
      end
      cool_nxt = ctrl_r.hc_auto ? cool_dem_s : ctrl_r.cool_obj;

      // Limits re-applied here so later limit changes also act
      base_c = clamp(ext(base_r), ext(cfg_r.base_min),
                     ext(cfg_r.base_max));
      off_c  = clamp(ext(offset_r), -ext(cfg_r.off_max),
                     ext(cfg_r.off_max));
      sum_c  = base_c + off_c;
      if (cool_nxt)
      begin
         sum_c = sum_c + ext(cfg_r.dead_zone);
      end

      case (setpoint_pkg::op_mode_type'(mode_nxt))
         setpoint_pkg::MODE_STANDBY:
         begin
            if (cool_nxt)
            begin
               sum_c = sum_c + ext(cfg_r.stby_inc);
            end
            else
            begin
               sum_c = sum_c - ext(cfg_r.stby_red);
            end
         end
         setpoint_pkg::MODE_NIGHT:
         begin
            if (cool_nxt)
            begin
               sum_c = sum_c + ext(cfg_r.night_inc);
            end
            else
            begin
               sum_c = sum_c - ext(cfg_r.night_red);
            end
         end
         default:
            sum_c = sum_c;
      endcase

      lim_c = clamp(sum_c, ext(cfg_r.frost_sp),
                    ext(cfg_r.heat_sp));

      if (mode_nxt == setpoint_pkg::MODE_PROTECT)
      begin
         cur_nxt = cool_nxt ? cfg_r.heat_sp
                            : cfg_r.frost_sp;
      end
      else if (settle_r != setpoint_pkg::SYNC_SETTLE)
      begin
         // Base may still be undefined on first power-up
         cur_nxt = cur_r;
      end
      else
      begin
         cur_nxt = lim_c[TW-1:0];
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cfg_r      <= setpoint_pkg::CFG_RESET;
         ctrl_r     <= setpoint_pkg::ctrl_type'(setpoint_pkg::CTRL_RESET);
         offset_r   <= '0;
         rot_prev_r <= '0;
         settle_r   <= '0;
         aw_held_r  <= 1'b0;
         w_held_r   <= 1'b0;
         waddr_r    <= '0;
         wdat_r     <= '0;
         wstb_r     <= '0;
         awready_r  <= 1'b0;
         wready_r   <= 1'b0;
         bvalid_r   <= 1'b0;
         bresp_r    <= setpoint_pkg::RESP_OKAY;
         arready_r  <= 1'b0;
         rvalid_r   <= 1'b0;
         rresp_r    <= setpoint_pkg::RESP_OKAY;
         rdata_r    <= '0;
         cur_r      <= setpoint_pkg::CFG_RESET.frost_sp;
         mode_r     <= setpoint_pkg::MODE_COMFORT;
         cool_r     <= 1'b0;
      end
      else
      begin
         cfg_r      <= cfg_nxt;
         ctrl_r     <= ctrl_nxt;
         offset_r   <= offset_nxt;
         rot_prev_r <= rot_prev_nxt;
         settle_r   <= settle_nxt;
         aw_held_r  <= aw_held_nxt;
         w_held_r   <= w_held_nxt;
         waddr_r    <= waddr_nxt;
         wdat_r     <= wdat_nxt;
         wstb_r     <= wstb_nxt;
         awready_r  <= awready_nxt;
         wready_r   <= wready_nxt;
         bvalid_r   <= bvalid_nxt;
         bresp_r    <= bresp_nxt;
         arready_r  <= arready_nxt;
         rvalid_r   <= rvalid_nxt;
         rresp_r    <= rresp_nxt;
         rdata_r    <= rdata_nxt;
         cur_r      <= cur_nxt;
         mode_r     <= mode_nxt;
         cool_r     <= cool_nxt;
      end
   end

   // Base is retained storage: a bus-supply reset must not clear it
   always_ff @(posedge clk)
   begin
      base_r <= base_nxt;
   end

   assign awready        = awready_r;
   assign wready         = wready_r;
   assign bvalid         = bvalid_r;
   assign bresp          = bresp_r;
   assign arready        = arready_r;
   assign rvalid         = rvalid_r;
   assign rresp          = rresp_r;
   assign rdata          = rdata_r;
   assign cur_setpoint   = cur_r;
   assign eff_mode       = mode_r;
   assign cooling_active = cool_r;

endmodule // setpoint_calculator

// ### sim/setpoint_properties.sv
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module setpoint_checker
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [15:0] cur_setpoint,
   input wire logic [1:0]  eff_mode,
   input wire logic        cooling_active
);
   // Bench never rewrites the protection limits
   localparam logic signed [15:0] FR = setpoint_pkg::CFG_RESET.frost_sp;
   localparam logic signed [15:0] HT = setpoint_pkg::CFG_RESET.heat_sp;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   wr_answer_a: assert property (awvalid && awready && wvalid && wready
      |=> !bvalid ##1 bvalid) else $error("write answer mistimed");
   wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped early");
   rd_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped early");
   rst_state_a: assert property ($fell(sys_rst) |-> cur_setpoint == 16'h0046
      && eff_mode == 2'h0 && !cooling_active) else $error("bad reset state");
   prot_heat_a: assert property (eff_mode == 2'h3 && cooling_active
      |-> cur_setpoint == HT) else $error("heat protection value wrong");
   prot_frost_a: assert property (eff_mode == 2'h3 && !cooling_active
      |-> cur_setpoint == FR) else $error("frost protection value wrong");
   sp_limits_a: assert property (eff_mode != 2'h3 |->
      $signed(cur_setpoint) >= FR && $signed(cur_setpoint) <= HT)
      else $error("set point outside protection limits");
endmodule // setpoint_checker
bind setpoint_calculator setpoint_checker u_chk (.clk(clk), .sys_rst(sys_rst),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
   .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
   .cur_setpoint(cur_setpoint), .eff_mode(eff_mode),
   .cooling_active(cooling_active));

// ### sim/pin_partner.sv
`timescale 1ns/1ps
// ****************
// Room side: window contact, demand, knob
// ****************
module pin_partner
(
   input wire logic        clk,
   input wire logic        win_req,
   input wire logic        cool_req,
   input wire logic        cold_req,
   input wire logic [15:0] rot_req,
   output logic            window_open_pin,
   output logic            cooling_demand_pin,
   output logic            cold_start_pin,
   output logic [15:0]     rotary_offset_pin
);
   // Contacts move just after an edge, never on it
   always_ff @(posedge clk)
   begin
      window_open_pin    <= win_req;
      cooling_demand_pin <= cool_req;
      cold_start_pin     <= cold_req;
      rotary_offset_pin  <= rot_req;
   end
endmodule // pin_partner

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam setpoint_pkg::cfg_type C = setpoint_pkg::CFG_RESET;
   logic        clk = 1'b0, sys_rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
   logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0, bvalid, rvalid;
   logic        awready, wready, arready, cool_act, win_p, cool_p, cold_p;
   logic        win_req = 1'b0, cool_req = 1'b0, cold_req = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d, x, seed = 32'h0000B519;
   logic [1:0]  bresp, rresp, eff_mode, r;
   logic [15:0] cur_sp, rot_p, rot_req = 16'h0000;
   int          errors = 0, num_checks = 0, base_m, off_m, mode_m, n;
   int          cobj_m, auto_m;

   always #12.5 clk = ~clk;

   setpoint_calculator u_dut (.clk(clk), .sys_rst(sys_rst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .window_open_pin(win_p), .cooling_demand_pin(cool_p),
      .cold_start_pin(cold_p), .rotary_offset_pin(rot_p),
      .cur_setpoint(cur_sp), .eff_mode(eff_mode), .cooling_active(cool_act));
   pin_partner u_pins (.clk(clk), .win_req(win_req), .cool_req(cool_req),
      .cold_req(cold_req), .rot_req(rot_req), .window_open_pin(win_p),
      .cooling_demand_pin(cool_p), .cold_start_pin(cold_p),
      .rotary_offset_pin(rot_p));

   // ****************
   // Model and bus tasks
   // ****************
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function int lim(int v, int lo, int hi);
      return v < lo ? lo : v > hi ? hi : v;
   endfunction
   function int cool_e();
      return auto_m ? cool_req : cobj_m;
   endfunction
   function int calc();
      int md;
      int s;
      md = win_req ? 3 : mode_m;
      if (md == 3)
         return cool_e() ? C.heat_sp : C.frost_sp;
      s = base_m + lim(off_m, -C.off_max, C.off_max);
      if (cool_e())
         s += C.dead_zone + (md == 1 ? C.stby_inc : md == 2 ? C.night_inc : 0);
      else
         s -= md == 1 ? C.stby_red : md == 2 ? C.night_red : 0;
      return lim(s, C.frost_sp, C.heat_sp);
   endfunction
   task cmp(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic pa;
      logic pd;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      pa = 1'b1;
      pd = 1'b1;
      while (pa | pd)
      begin
         @(posedge clk);
         pa = pa & ~awready;
         pd = pd & ~wready;
         awvalid <= pa;
         wvalid <= pd;
      end
      repeat (rnd() % 3) @(posedge clk);
      bready <= 1'b1;
      do @(posedge clk); while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      repeat (rnd() % 3) @(posedge clk);
      rready <= 1'b1;
      do @(posedge clk); while (!rvalid);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task check_out();
      repeat (8) @(posedge clk);
      cmp(cur_sp, calc());
      cmp(eff_mode, win_req ? 3 : mode_m);
      cmp(cool_act, cool_e());
      rd(setpoint_pkg::OFS_CUR_SP, d, r);
      cmp(d, calc());
      rd(setpoint_pkg::OFS_BASE, d, r);
      cmp(d, base_m);
   endtask
   task test_done();
      if (errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ****************
   // Scenarios
   // ****************
   initial
   begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clk);
      cold_req <= 1'b0;
      base_m = C.after_load;
      off_m = 0;
      mode_m = 0;
      cobj_m = 0;
      auto_m = 1;
      wr(setpoint_pkg::OFS_OFFSET, 32'h0, r);
      check_out();
      for (int i = 0; i < 40; i++)
      begin
         x = rnd();
         mode_m = x[1:0];
         cobj_m = x[2];
         auto_m = x[3];
         cool_req <= x[4];
         win_req <= x[5] & x[6];
         wr(setpoint_pkg::OFS_CTRL, {27'h0, 1'b1, x[2], x[3], x[1:0]}, r);
         cmp(r, setpoint_pkg::RESP_OKAY);
         d = 32'h00000064 + x[15:8];
         wr(setpoint_pkg::OFS_BASE, d, r);
         base_m = lim(d, C.base_min, C.base_max);
         n = int'(x[21:16]) - 32;
         d = n;
         if (x[24])
         begin
            if (d[15:0] !== rot_req)
               off_m = n;
            rot_req <= d[15:0];
         end
         else
         begin
            wr(setpoint_pkg::OFS_OFFSET, d, r);
            off_m = n;
         end
         check_out();
      end
      mode_m = 0;
      cobj_m = 0;
      auto_m = 0;
      wr(setpoint_pkg::OFS_CTRL, 32'h0, r);
      wr(setpoint_pkg::OFS_BASE, 32'h000000FA, r);
      rot_req <= rot_req ^ 16'h0003;
      check_out();
      wr(8'h40, 32'h0, r);
      cmp(r, setpoint_pkg::RESP_SLVERR);
      rd(8'h40, d, r);
      cmp(r, setpoint_pkg::RESP_SLVERR);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clk);
      auto_m = 1;
      off_m = 0;
      wr(setpoint_pkg::OFS_OFFSET, 32'h0, r);
      check_out();
      test_done();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      test_done();
   end
endmodule // testbench
